// ### shared/ctm_pkg.sv
// constants and types shared by the channel trigger mode block
`default_nettype none
package ctm_pkg;
    localparam int NUM_CH = 2;
    localparam int SAMPLE_W = 12;
    localparam int LEVEL_W = 10;
    localparam int ADDR_W = 16;
    // register numbers as printed; byte address is four times the number
    localparam logic [ADDR_W-1:0] IDX_ENABLE_MASK = 16'h9e0c;
    localparam logic [ADDR_W-1:0] IDX_MODES_AVAIL = 16'h9e98;
    localparam logic [ADDR_W-1:0] IDX_CH0_MODE = 16'h9ea2;
    localparam logic [ADDR_W-1:0] IDX_CH1_MODE = 16'h9ea3;
    localparam logic [ADDR_W-1:0] IDX_CH0_LEVEL0 = 16'ha4d8;
    localparam logic [ADDR_W-1:0] IDX_CH1_LEVEL0 = 16'ha4d9;
    localparam logic [ADDR_W-1:0] IDX_CH0_LEVEL1 = 16'ha53c;
    localparam logic [ADDR_W-1:0] IDX_CH1_LEVEL1 = 16'ha53d;
    localparam logic [ADDR_W-1:0] IDX_COMBINE = 16'h9e0d;
    localparam logic [ADDR_W-1:0] IDX_ERROR = 16'h9e0e;
    localparam logic [ADDR_W-1:0] IDX_TRIG_STATUS = 16'h9e0f;
    localparam int BIT_EN_CH0 = 0;
    localparam int BIT_EN_CH1 = 1;
    localparam logic [31:0] ENABLE_MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h000;
    // number of channels actually fitted; unfitted channels refuse mode writes
    localparam int FITTED_CH = 2;
    localparam logic [31:0] MODE_DISABLED = 32'h0000_0000;
    localparam logic [31:0] MODE_RISING_EDGE = 32'h0000_0001;
    localparam logic [31:0] MODE_FALLING_EDGE = 32'h0000_0002;
    localparam logic [31:0] MODE_EITHER_EDGE = 32'h0000_0004;
    localparam logic [31:0] MODE_HIGH_LEVEL = 32'h0000_0008;
    localparam logic [31:0] MODE_LOW_LEVEL = 32'h0000_0010;
    localparam logic [31:0] MODE_WINDOW_ENTER = 32'h0000_0020;
    localparam logic [31:0] MODE_WINDOW_EXIT = 32'h0000_0040;
    localparam logic [31:0] MODE_INSIDE_WINDOW = 32'h0000_0080;
    localparam logic [31:0] MODE_OUTSIDE_WINDOW = 32'h0000_0100;
    localparam logic [31:0] HYSTERESIS_ARMING_FLAG = 32'h0100_0000;
    localparam logic [31:0] MODES_AVAILABLE = 32'h0100_01ff & ~32'h0000_0000;
    typedef enum logic [3:0] {
        CTM_OFF = 4'h0,
        CTM_RISE = 4'h1,
        CTM_FALL = 4'h3,
        CTM_BOTH = 4'h2,
        CTM_RISE_ARM = 4'h6,
        CTM_FALL_ARM = 4'h7,
        CTM_HIGH = 4'h5,
        CTM_LOW = 4'h4,
        CTM_WIN_ENTER = 4'hc,
        CTM_WIN_EXIT = 4'hd,
        CTM_WIN_IN = 4'hf,
        CTM_WIN_OUT = 4'he
    } ctm_sel_t;
    // valid mode words decode to a selector, unknown words to off
    function automatic ctm_sel_t ctm_decode(input logic [31:0] code);
        ctm_sel_t sel;
        sel = CTM_OFF;
        case (code)
            MODE_RISING_EDGE: sel = CTM_RISE;
            MODE_FALLING_EDGE: sel = CTM_FALL;
            MODE_EITHER_EDGE: sel = CTM_BOTH;
            MODE_RISING_EDGE | HYSTERESIS_ARMING_FLAG: sel = CTM_RISE_ARM;
            MODE_FALLING_EDGE | HYSTERESIS_ARMING_FLAG: sel = CTM_FALL_ARM;
            MODE_HIGH_LEVEL: sel = CTM_HIGH;
            MODE_LOW_LEVEL: sel = CTM_LOW;
            MODE_WINDOW_ENTER: sel = CTM_WIN_ENTER;
            MODE_WINDOW_EXIT: sel = CTM_WIN_EXIT;
            MODE_INSIDE_WINDOW: sel = CTM_WIN_IN;
            MODE_OUTSIDE_WINDOW: sel = CTM_WIN_OUT;
            default: sel = CTM_OFF;
        endcase
        return sel;
    endfunction
    function automatic logic ctm_code_ok(input logic [31:0] code);
        return (code == MODE_DISABLED) || (ctm_decode(code) != CTM_OFF);
    endfunction
endpackage
`default_nettype wire

// ### shared/ctm_chan_if.sv
// per-channel link between register file and detector
`default_nettype none
interface ctm_chan_if;
    import ctm_pkg::*;
    ctm_sel_t sel;
    logic enable;
    logic signed [LEVEL_W-1:0] level0;
    logic signed [LEVEL_W-1:0] level1;
    logic hit;
    modport ctrl (output sel, output enable, output level0, output level1, input hit);
    modport det (input sel, input enable, input level0, input level1, output hit);
endinterface
`default_nettype wire

// ### verilog/ctm_detector.sv
// one channel's trigger condition detector
`default_nettype none
module ctm_detector
    import ctm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    ctm_chan_if.det ch
);
    logic signed [LEVEL_W-1:0] cur;
    logic signed [LEVEL_W-1:0] prev_reg;
    logic prev_valid_reg;
    logic armed_reg;
    logic armed_next;
    logic hit_next;
    logic above0, below0, above1, below1, p_above0, p_below0, p_above1, p_below1;
    logic in_win, p_in_win;

    assign cur = sample_i[SAMPLE_W-1 -: LEVEL_W];
    assign above0 = cur > ch.level0;
    assign below0 = cur < ch.level0;
    assign above1 = cur > ch.level1;
    assign below1 = cur < ch.level1;
    assign p_above0 = prev_reg > ch.level0;
    assign p_below0 = prev_reg < ch.level0;
    assign p_above1 = prev_reg > ch.level1;
    assign p_below1 = prev_reg < ch.level1;
    // level 0 bounds the window from above, level 1 from below
    assign in_win = !above0 && !below1;
    assign p_in_win = !p_above0 && !p_below1;

    always_comb
    begin
        hit_next = 1'b0;
        armed_next = armed_reg;
        case (ch.sel)
            CTM_RISE: hit_next = prev_valid_reg && !p_above0 && above0;
            CTM_FALL: hit_next = prev_valid_reg && !p_below0 && below0;
            CTM_BOTH: hit_next = prev_valid_reg && ((!p_above0 && above0) || (!p_below0 && below0));
            CTM_RISE_ARM:
            begin
                // arm below level 1, fire once through level 0
                if (below1)
                    armed_next = 1'b1;
                if (armed_reg && prev_valid_reg && !p_above0 && above0)
                begin
                    hit_next = 1'b1;
                    armed_next = 1'b0;
                end
            end
            CTM_FALL_ARM:
            begin
                if (above0)
                    armed_next = 1'b1;
                if (armed_reg && prev_valid_reg && !p_below1 && below1)
                begin
                    hit_next = 1'b1;
                    armed_next = 1'b0;
                end
            end
            CTM_HIGH: hit_next = above0;
            CTM_LOW: hit_next = below0;
            CTM_WIN_ENTER: hit_next = prev_valid_reg && !p_in_win && in_win;
            CTM_WIN_EXIT: hit_next = prev_valid_reg && p_in_win && !in_win;
            CTM_WIN_IN: hit_next = in_win;
            CTM_WIN_OUT: hit_next = !in_win;
            default: hit_next = 1'b0;
        endcase
        if (!ch.enable)
        begin
            hit_next = 1'b0;
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            prev_reg <= '0;
            prev_valid_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= cur;
            prev_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            armed_reg <= 1'b0;
        else
            armed_reg <= armed_next;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            ch.hit <= 1'b0;
        else
            ch.hit <= hit_next;
    end

    chk_level_high: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ch.enable && ch.sel == CTM_HIGH && above0) ##1 (ch.enable && ch.sel == CTM_HIGH) |-> ch.hit)
        else $error("high level not flagged");
    chk_disabled_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !ch.enable |=> !ch.hit)
        else $error("disabled channel produced a hit");
endmodule // ctm_detector
`default_nettype wire

// ### verilog/ctm_trigger_top.sv
// two-channel trigger mode selection with register port
//////////////////////////////////////////////////////////////////////
// Function
// - only enabled channels contribute triggers
// - enable mask register, bit0 enables channel0
// - enabled triggers combine by OR or AND
// - read-only mask of supported modes
// - per-channel mode registers, gated by enable
// - mode write to unfitted channel flags error
// - code zero disables channel detection
// - code 1 detects rising edges
// - code 2 detects falling edges
// - code 4 detects both edges
// - rearmed rising edge, armed via level1
// - rearmed falling edge, armed via level0
// - code 10h detects low level
// - code 8 detects high level
// - code 20h fires entering window
// - code 40h fires leaving window
// - code 80h flags inside window
// - code 100h flags outside window
// - two signed levels per channel
// - compare sample upper bits with levels
// - rising edge means crossing low to high
//////////////////////////////////////////////////////////////////////
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
module ctm_trigger_top
    import ctm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    input wire logic signed [SAMPLE_W-1:0] ch0_sample_i,
    input wire logic signed [SAMPLE_W-1:0] ch1_sample_i,
    output logic trigger_o,
    output logic [NUM_CH-1:0] chan_hit_o
);
    logic [31:0] enable_mask_reg;
    logic [31:0] mode_reg [NUM_CH];
    logic signed [LEVEL_W-1:0] level0_reg [NUM_CH];
    logic signed [LEVEL_W-1:0] level1_reg [NUM_CH];
    logic combine_and_reg;
    logic [1:0] error_reg;
    logic [31:0] rdata_next;
    logic trigger_next;
    logic [NUM_CH-1:0] hits;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] mode_wr;
    logic mode_wr_bad;
    logic mode_wr_unfitted;

    ctm_chan_if chan [NUM_CH] ();

    default clocking cb_core @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    //////////////////////////////////////////////////////////////////////
    // channel detectors
    ctm_detector u_det0 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .sample_i(ch0_sample_i),
        .ch(chan[0])
    );
    ctm_detector u_det1 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .sample_i(ch1_sample_i),
        .ch(chan[1])
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            assign chan[gi].sel = ctm_decode(mode_reg[gi]);
            // a channel is active only when masked in and not in mode zero
            assign active[gi] = enable_mask_reg[gi] && (mode_reg[gi] != MODE_DISABLED);
            assign chan[gi].enable = active[gi];
            assign chan[gi].level0 = level0_reg[gi];
            assign chan[gi].level1 = level1_reg[gi];
            assign hits[gi] = chan[gi].hit;
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // register writes
    assign mode_wr[0] = reg_write_i && reg_addr_i == IDX_CH0_MODE;
    assign mode_wr[1] = reg_write_i && reg_addr_i == IDX_CH1_MODE;
    // unknown codes are refused just like unfitted channels
    assign mode_wr_bad = (|mode_wr) && !ctm_code_ok(reg_wdata_i);
    assign mode_wr_unfitted = mode_wr[1] && (FITTED_CH < 2);

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            enable_mask_reg <= ENABLE_MASK_RESET;
        else if (reg_write_i && reg_addr_i == IDX_ENABLE_MASK)
            enable_mask_reg <= {30'h0, reg_wdata_i[BIT_EN_CH1:BIT_EN_CH0]};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            mode_reg[0] <= MODE_RESET;
            mode_reg[1] <= MODE_RESET;
        end
        else
        begin
            if (mode_wr[0] && !mode_wr_bad)
                mode_reg[0] <= reg_wdata_i;
            if (mode_wr[1] && !mode_wr_bad && !mode_wr_unfitted)
                mode_reg[1] <= reg_wdata_i;
        end
    end

    // error flags: bit0 unfitted channel, bit1 unsupported code; write 1 clears, set wins
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            error_reg <= 2'h0;
        else
        begin
            error_reg <= (error_reg & ~((reg_write_i && reg_addr_i == IDX_ERROR) ? reg_wdata_i[1:0] : 2'h0))
                | {mode_wr_bad, mode_wr_unfitted};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            level0_reg[0] <= LEVEL_RESET;
            level0_reg[1] <= LEVEL_RESET;
            level1_reg[0] <= LEVEL_RESET;
            level1_reg[1] <= LEVEL_RESET;
        end
        else if (reg_write_i)
        begin
            case (reg_addr_i)
                IDX_CH0_LEVEL0: level0_reg[0] <= reg_wdata_i[LEVEL_W-1:0];
                IDX_CH1_LEVEL0: level0_reg[1] <= reg_wdata_i[LEVEL_W-1:0];
                IDX_CH0_LEVEL1: level1_reg[0] <= reg_wdata_i[LEVEL_W-1:0];
                IDX_CH1_LEVEL1: level1_reg[1] <= reg_wdata_i[LEVEL_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            combine_and_reg <= 1'b0;
        else if (reg_write_i && reg_addr_i == IDX_COMBINE)
            combine_and_reg <= reg_wdata_i[0];
    end

    //////////////////////////////////////////////////////////////////////
    // register reads, one cycle latency
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (reg_addr_i)
            IDX_ENABLE_MASK: rdata_next = enable_mask_reg;
            IDX_MODES_AVAIL: rdata_next = MODES_AVAILABLE;
            IDX_CH0_MODE: rdata_next = mode_reg[0];
            IDX_CH1_MODE: rdata_next = mode_reg[1];
            IDX_CH0_LEVEL0: rdata_next = 32'(level0_reg[0]);
            IDX_CH1_LEVEL0: rdata_next = 32'(level0_reg[1]);
            IDX_CH0_LEVEL1: rdata_next = 32'(level1_reg[0]);
            IDX_CH1_LEVEL1: rdata_next = 32'(level1_reg[1]);
            IDX_COMBINE: rdata_next = {31'h0, combine_and_reg};
            IDX_ERROR: rdata_next = {30'h0, error_reg};
            IDX_TRIG_STATUS: rdata_next = {29'h0, trigger_o, chan_hit_o};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_read_i)
            reg_rdata_o <= rdata_next;
        else
            reg_rdata_o <= 32'h0000_0000;
    end

    //////////////////////////////////////////////////////////////////////
    // combining; AND needs every active channel, and none active means no trigger
    always_comb
    begin
        if (combine_and_reg)
            trigger_next = (|active) && ((hits & active) == active);
        else
            trigger_next = |(hits & active);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            trigger_o <= 1'b0;
            chan_hit_o <= '0;
        end
        else
        begin
            trigger_o <= trigger_next;
            chan_hit_o <= hits & active;
        end
    end

    //////////////////////////////////////////////////////////////////////
    sequence s_mode_write_ok;
        mode_wr[0] && ctm_code_ok(reg_wdata_i);
    endsequence
    sequence s_mask_off;
        !enable_mask_reg[0] && !enable_mask_reg[1];
    endsequence

    chk_mode_store: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_mode_write_ok |=> mode_reg[0] == $past(reg_wdata_i))
        else $error("mode write not stored");
    chk_bad_code_err: assert property (@(posedge core_clk_i) disable iff (reset_i)
        mode_wr_bad |=> error_reg[1] && mode_reg[0] == $past(mode_reg[0]))
        else $error("bad mode code not refused");
    chk_avail_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_read_i && reg_addr_i == IDX_MODES_AVAIL) |=> reg_rdata_o == MODES_AVAILABLE)
        else $error("available modes read wrong");
    chk_mask_silence: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_mask_off [*3] |-> !trigger_o)
        else $error("trigger without enabled channel");
    chk_mask_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_write_i && reg_addr_i == IDX_ENABLE_MASK) |=> enable_mask_reg[0] == $past(reg_wdata_i[0]))
        else $error("enable bit not stored");
    chk_or_combine: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!combine_and_reg && |(hits & active)) |=> trigger_o)
        else $error("or combine missed");
    chk_and_combine: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (combine_and_reg && active == 2'h3 && hits != 2'h3) |=> !trigger_o)
        else $error("and combine fired early");
    chk_zero_mode_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (mode_reg[0] == MODE_DISABLED) [*2] |-> !chan_hit_o[0])
        else $error("mode zero channel hit");

    sequence s_mask_wr;
        reg_write_i && reg_addr_i == IDX_ENABLE_MASK;
    endsequence

    sequence s_err_wr;
        reg_write_i && reg_addr_i == IDX_ERROR;
    endsequence

    chk_mode1_store: assert property (
        (mode_wr[1] && !mode_wr_bad && !mode_wr_unfitted) |=> mode_reg[1] == $past(reg_wdata_i))
        else $error("mode1 write not stored");

    chk_mode1_keep: assert property (
        (mode_wr[1] && mode_wr_bad) |=> mode_reg[1] == $past(mode_reg[1]) && error_reg[1])
        else $error("bad mode1 code stored");

    chk_error_read: assert property (
        (reg_read_i && reg_addr_i == IDX_ERROR) |=> reg_rdata_o == {30'h0, $past(error_reg)})
        else $error("error flags read wrong");

    chk_err_sticky: assert property (
        (error_reg[1] && !(reg_write_i && reg_addr_i == IDX_ERROR)) |=> error_reg[1])
        else $error("error flag lost");

    chk_err_clear: assert property (
        s_err_wr ##0 reg_wdata_i[1] |=> !error_reg[1])
        else $error("error flag not cleared");

    chk_mask1_write: assert property (
        s_mask_wr |=> enable_mask_reg[1] == $past(reg_wdata_i[1]))
        else $error("enable bit1 not stored");

    chk_mask_read: assert property (
        (reg_read_i && reg_addr_i == IDX_ENABLE_MASK) |=> reg_rdata_o == $past(enable_mask_reg))
        else $error("enable mask read wrong");

    chk_mode0_read: assert property (
        (reg_read_i && reg_addr_i == IDX_CH0_MODE) |=> reg_rdata_o == $past(mode_reg[0]))
        else $error("mode0 read wrong");

    chk_mode1_read: assert property (
        (reg_read_i && reg_addr_i == IDX_CH1_MODE) |=> reg_rdata_o == $past(mode_reg[1]))
        else $error("mode1 read wrong");

    chk_ch0_mask_quiet: assert property (
        (!enable_mask_reg[0]) [*2] |-> !chan_hit_o[0])
        else $error("masked channel0 hit");

    chk_ch1_mask_quiet: assert property (
        (!enable_mask_reg[1]) [*2] |-> !chan_hit_o[1])
        else $error("masked channel1 hit");

    chk_zero_mode1_off: assert property (
        (mode_reg[1] == MODE_DISABLED) [*2] |-> !chan_hit_o[1])
        else $error("mode zero channel1 hit");

    chk_and_full: assert property (
        (combine_and_reg && active != 2'h0 && (hits & active) == active) |=> trigger_o)
        else $error("and combine missed");

    chk_or_quiet: assert property (
        (!combine_and_reg && (hits & active) == 2'h0) |=> !trigger_o)
        else $error("or combine spurious");

    chk_lvl1_ch0_write: assert property (
        (reg_write_i && reg_addr_i == IDX_CH0_LEVEL1) |=> level1_reg[0] == $past(reg_wdata_i[LEVEL_W-1:0]))
        else $error("level1 ch0 not stored");

    chk_hit0_pass: assert property (
        (hits[0] && active[0]) |=> chan_hit_o[0])
        else $error("channel0 hit lost");

    chk_hit1_pass: assert property (
        (hits[1] && active[1]) |=> chan_hit_o[1])
        else $error("channel1 hit lost");

    chk_lvl0_ch0_write: assert property (
        (reg_write_i && reg_addr_i == IDX_CH0_LEVEL0) |=> level0_reg[0] == $past(reg_wdata_i[LEVEL_W-1:0]))
        else $error("level0 ch0 not stored");

    chk_lvl0_ch1_write: assert property (
        (reg_write_i && reg_addr_i == IDX_CH1_LEVEL0) |=> level0_reg[1] == $past(reg_wdata_i[LEVEL_W-1:0]))
        else $error("level0 ch1 not stored");

    chk_level_readback: assert property (
        (reg_read_i && reg_addr_i == IDX_CH0_LEVEL1) |=> reg_rdata_o == 32'($past(level1_reg[0])))
        else $error("level not sign extended");

    chk_or_status: assert property (
        (!$past(combine_and_reg) && chan_hit_o != 2'h0) |-> trigger_o)
        else $error("hit without or trigger");
endmodule // ctm_trigger_top
`default_nettype wire

// ### tb/ctm_adc_model.sv
// sample source standing in for the two converters
`default_nettype none
module ctm_adc_model
    import ctm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic signed [LEVEL_W-1:0] ch0_top_i,
    input wire logic signed [LEVEL_W-1:0] ch1_top_i,
    output logic signed [SAMPLE_W-1:0] ch0_sample_o,
    output logic signed [SAMPLE_W-1:0] ch1_sample_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] lsb_reg = 2'h0;
    // low bits churn every sample so any use of them shows up
    always_ff @(posedge core_clk_i)
    begin
        lsb_reg <= lsb_reg + 2'h1;
    end
    assign ch0_sample_o = {ch0_top_i, lsb_reg};
    assign ch1_sample_o = {ch1_top_i, ~lsb_reg};
endmodule // ctm_adc_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the channel trigger mode block
`default_nettype none
module tb
    import ctm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [31:0] mode;
        logic [1:0] mask;
        logic signed [9:0] a;
        logic signed [9:0] b;
        logic hit;
    } ctm_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic trig;
    logic [NUM_CH-1:0] hit;
    logic signed [LEVEL_W-1:0] t0 = 10'sh000;
    logic signed [LEVEL_W-1:0] t1 = 10'sh000;
    logic signed [SAMPLE_W-1:0] s0;
    logic signed [SAMPLE_W-1:0] s1;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    ctm_row_t rows [15];
    //////////////////////////////////////////////////////////////////////
    ctm_adc_model adc (.core_clk_i(clk), .ch0_top_i(t0), .ch1_top_i(t1), .ch0_sample_o(s0), .ch1_sample_o(s1));
    ctm_trigger_top dut (
        .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s),
        .reg_read_i(rd_s), .reg_rdata_o(rdata), .ch0_sample_i(s0), .ch1_sample_i(s1),
        .trigger_o(trig), .chan_hit_o(hit)
    );
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the roughly 300 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask
    // settle on a, step to b; hit and trigger both stand two edges later
    task automatic step(input logic signed [9:0] a, input logic signed [9:0] b, input logic [1:0] eh, input logic et);
        @(posedge clk);
        t0 <= a;
        repeat (4) @(posedge clk);
        t0 <= b;
        repeat (2) @(posedge clk);
        #1;
        check("chan_hit", {30'h0, hit}, {30'h0, eh});
        check("trigger", {31'h0, trig}, {31'h0, et});
    endtask
    task automatic levels();
        wr(IDX_CH0_LEVEL0, 32'h0000_0005);
        wr(IDX_CH0_LEVEL1, 32'hffff_fffb);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial
    begin
        rows = '{
            '{MODE_RISING_EDGE, 2'h1, 10'sd0, 10'sd10, 1'b1},
            '{MODE_RISING_EDGE, 2'h1, 10'sd10, 10'sd0, 1'b0},
            '{MODE_RISING_EDGE, 2'h0, 10'sd0, 10'sd10, 1'b0},
            '{MODE_FALLING_EDGE, 2'h1, 10'sd10, 10'sd0, 1'b1},
            '{MODE_FALLING_EDGE, 2'h1, 10'sd0, 10'sd10, 1'b0},
            '{MODE_EITHER_EDGE, 2'h1, 10'sd10, 10'sd0, 1'b1},
            '{MODE_EITHER_EDGE, 2'h1, 10'sd0, 10'sd10, 1'b1},
            '{MODE_HIGH_LEVEL, 2'h1, 10'sd10, 10'sd10, 1'b1},
            '{MODE_LOW_LEVEL, 2'h1, 10'sd10, -10'sd10, 1'b1},
            '{MODE_WINDOW_ENTER, 2'h1, 10'sd10, 10'sd0, 1'b1},
            '{MODE_WINDOW_EXIT, 2'h1, 10'sd0, 10'sd10, 1'b1},
            '{MODE_INSIDE_WINDOW, 2'h1, 10'sd0, 10'sd5, 1'b1},
            '{MODE_OUTSIDE_WINDOW, 2'h1, 10'sd0, 10'sd0, 1'b0},
            '{MODE_DISABLED, 2'h1, 10'sd0, 10'sd10, 1'b0},
            '{MODE_FALLING_EDGE | HYSTERESIS_ARMING_FLAG, 2'h1, 10'sd10, -10'sd10, 1'b1}
        };
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc("mask reset", IDX_ENABLE_MASK, ENABLE_MASK_RESET);
        rdc("mode reset", IDX_CH1_MODE, MODE_RESET);
        rdc("modes available", IDX_MODES_AVAIL, MODES_AVAILABLE);
        wr(IDX_MODES_AVAIL, 32'h0000_0000);
        rdc("modes available ro", IDX_MODES_AVAIL, MODES_AVAILABLE);
        wr(IDX_CH1_MODE, 32'h0000_0003);
        rdc("bad mode kept", IDX_CH1_MODE, MODE_RESET);
        rdc("error flag", IDX_ERROR, 32'h0000_0002);
        wr(IDX_ERROR, 32'h0000_0002);
        rdc("error cleared", IDX_ERROR, 32'h0000_0000);
        rdc("unmapped", 16'h0001, 32'h0000_0000);
        levels();
        rdc("level sign", IDX_CH0_LEVEL1, 32'hffff_fffb);
        $display("register test done");
        foreach (rows[i])
        begin
            wr(IDX_CH0_MODE, rows[i].mode);
            wr(IDX_ENABLE_MASK, {30'h0, rows[i].mask});
            rdc("mode readback", IDX_CH0_MODE, rows[i].mode);
            step(rows[i].a, rows[i].b, {1'b0, rows[i].hit}, rows[i].hit);
        end
        $display("mode table test done");
        // both channels high-level, combined by and then or
        wr(IDX_CH1_LEVEL0, 32'h0000_0005);
        wr(IDX_CH0_MODE, MODE_HIGH_LEVEL);
        wr(IDX_CH1_MODE, MODE_HIGH_LEVEL);
        wr(IDX_ENABLE_MASK, 32'h0000_0003);
        wr(IDX_COMBINE, 32'h0000_0001);
        t1 <= -10'sd10;
        step(10'sd10, 10'sd10, 2'b01, 1'b0);
        @(posedge clk);
        t1 <= 10'sd10;
        step(10'sd10, 10'sd10, 2'b11, 1'b1);
        wr(IDX_COMBINE, 32'h0000_0000);
        step(-10'sd10, -10'sd10, 2'b10, 1'b1);
        $display("combine test done");
        // reset in mid-run clears the arming state as well
        @(posedge clk);
        t0 <= 10'sd0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("trigger in reset", {31'h0, trig}, 32'h0000_0000);
        rdc("mask after reset", IDX_ENABLE_MASK, ENABLE_MASK_RESET);
        rdc("mode after reset", IDX_CH0_MODE, MODE_RESET);
        levels();
        wr(IDX_ENABLE_MASK, 32'h0000_0001);
        wr(IDX_CH0_MODE, MODE_RISING_EDGE | HYSTERESIS_ARMING_FLAG);
        step(10'sd0, 10'sd10, 2'b00, 1'b0);
        step(-10'sd10, 10'sd10, 2'b01, 1'b1);
        $display("rearm test done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
